//--- inc/enc_pkg.sv
// package for the quadrature encoder block: register map, field layouts,
// reset values, mode codes and divider limits.
// assumes a single 25 MHz clock and a 16-bit register port with byte enables.
`default_nettype none

package enc_pkg;

  // register port geometry
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 3;

  // register word indices
  localparam logic [2:0] ADDR_CTRL = 3'h0;  // encoder_control_status
  localparam logic [2:0] ADDR_FILT = 3'h1;  // input_filter_control
  localparam logic [2:0] ADDR_POS  = 3'h2;  // position_count
  localparam logic [2:0] ADDR_MAX  = 3'h3;  // maximum_count
  localparam logic [2:0] ADDR_STAT = 3'h4;  // interrupt status, write one to clear
  localparam logic [2:0] ADDR_MASK = 3'h5;  // interrupt mask

  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] FILT_RST = 16'h0000;
  localparam logic [15:0] POS_RST  = 16'h0000;
  localparam logic [15:0] MAX_RST  = 16'hffff;

  // writable bits; reserved and read-only bits read back as stored or zero
  localparam logic [15:0] CTRL_WMASK = 16'hafff;
  localparam logic [15:0] CTRL_DIR   = 16'h0800;
  localparam logic [15:0] FILT_WMASK = 16'h07f0;
  localparam logic [15:0] FULL_WMASK = 16'hffff;

  // mode selector codes
  localparam logic [2:0] MODE_OFF    = 3'h0;
  localparam logic [2:0] MODE_TIMER  = 3'h1;
  localparam logic [2:0] MODE_X2_IDX = 3'h4;
  localparam logic [2:0] MODE_X2_MAX = 3'h5;
  localparam logic [2:0] MODE_X4_IDX = 3'h6;
  localparam logic [2:0] MODE_X4_MAX = 3'h7;

  // timer prescale codes and terminal counts
  localparam logic [1:0] PRE_1   = 2'h0;
  localparam logic [1:0] PRE_8   = 2'h1;
  localparam logic [1:0] PRE_64  = 2'h2;
  localparam logic [7:0] LIM_1   = 8'h00;
  localparam logic [7:0] LIM_8   = 8'h07;
  localparam logic [7:0] LIM_64  = 8'h3f;
  localparam logic [7:0] LIM_256 = 8'hff;

  // interrupt event bits
  localparam int IRQ_W   = 2;
  localparam int EV_ERR  = 0;
  localparam int EV_POS  = 1;

  // filter depth in filter clocks and number of filtered pins
  localparam int FLT_DEPTH = 3;
  localparam int NPIN      = 3;

  // control/status register layout
  typedef struct packed {
    logic       count_error_flag;
    logic       rsv14;
    logic       idle_stop;
    logic       index_state;
    logic       direction_status;
    logic [2:0] mode_selector;
    logic       phase_swap;
    logic       pos_out_en;
    logic       timer_gate;
    logic [1:0] timer_prescale;
    logic       index_reset_enable;
    logic       timer_clock_source;
    logic       direction_source;
  } enc_ctrl_t;

  // filter control register layout
  typedef struct packed {
    logic [4:0] rsv_hi;
    logic [1:0] index_match_value;
    logic       count_error_irq_disable;
    logic       filter_enable;
    logic [2:0] filter_clock_divide;
    logic [3:0] rsv_lo;
  } enc_filt_t;

endpackage

`default_nettype wire

//--- logic/enc_input_filter.sv
// one input pin: two-flop synchroniser and a three-sample noise filter.
// assumes tick is a one-cycle enable from the filter clock divider.
`default_nettype none

module enc_input_filter (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // filter clock enable
  input  wire logic tick,
  // pin side
  input  wire logic pin,
  // synchronised and filtered levels
  output logic      sync_out,
  output logic      filt_out
);

  logic                              meta_reg;  // first synchroniser stage
  logic [enc_pkg::FLT_DEPTH-1:0]     hist_reg;  // last samples on tick

  // synchroniser: only the second stage reads the first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_reg <= 1'h0;
      sync_out <= 1'h0;
    end else begin
      meta_reg <= pin;
      sync_out <= meta_reg;
    end
  end

  // sample on each filter clock, pass a level once all samples agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hist_reg <= '0;
      filt_out <= 1'h0;
    end else if (tick) begin
      hist_reg <= {hist_reg[enc_pkg::FLT_DEPTH-2:0], sync_out};
      if (&hist_reg) begin
        filt_out <= 1'h1;
      end else if (~|hist_reg) begin
        filt_out <= 1'h0;
      end
    end
  end

  // output moves only on a filter clock
  a_filter_tick: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(filt_out) |-> $past(tick) && ($past(hist_reg) == {enc_pkg::FLT_DEPTH{filt_out}}))
    else $error("filter output moved without three stable samples");

endmodule

`default_nettype wire

//--- logic/enc_quad_decoder.sv
// quadrature encoder interface: decoder, position counter, timer mode,
// input filters, register port and interrupt.
// assumes pins are asynchronous, the register master is on ref_clk.
//
// The strobed register port and the register addresses were decided locally.
`default_nettype none

module enc_quad_decoder (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  // register port
  input  wire logic [enc_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [enc_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic [1:0]                   reg_be,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [enc_pkg::DATA_W-1:0]   reg_rdata,
  // encoder pins
  input  wire logic                         phase_a_input,
  input  wire logic                         phase_b_input,
  input  wire logic                         index_input,
  // device idle request, same clock
  input  wire logic                         idle_mode,
  // interrupt
  output logic                              irq
);

  // registers
  enc_pkg::enc_ctrl_t               ctrl_reg;   // control/status
  enc_pkg::enc_filt_t               filt_reg;   // filter control
  logic [enc_pkg::DATA_W-1:0]       pos_reg;    // position count
  logic [enc_pkg::DATA_W-1:0]       max_reg;    // maximum count
  logic [enc_pkg::IRQ_W-1:0]        stat_reg;   // sticky events
  logic [enc_pkg::IRQ_W-1:0]        mask_reg;   // event enables
  logic [7:0]                       fdiv_reg;   // filter clock divider
  logic [7:0]                       pre_reg;    // timer prescaler
  logic                             a_q;        // previous phase A
  logic                             b_q;        // previous phase B
  logic                             idx_q;      // previous index

  // pin path
  logic [enc_pkg::NPIN-1:0]         pins;       // {index, B, A}
  logic [enc_pkg::NPIN-1:0]         sync_v;     // synchronised pins
  logic [enc_pkg::NPIN-1:0]         filt_v;     // filtered pins
  logic [enc_pkg::NPIN-1:0]         sel_v;      // pins used by decoder
  logic                             fl_tick;    // filter clock enable
  logic [7:0]                       fdiv_lim;   // filter divider limit
  logic                             a_in;       // phase A after swap
  logic                             b_in;       // phase B after swap
  logic                             idx_in;     // index level

  // decode
  logic                             is_quad;    // quadrature modes
  logic                             is_x4;      // four counts per cycle
  logic                             idx_mode;   // index reset modes
  logic                             is_timer;   // timer mode
  logic                             wrap_mode;  // match against maximum
  logic                             running;    // not stopped by idle
  logic                             a_chg;      // phase A moved
  logic                             b_chg;      // phase B moved
  logic                             both_chg;   // illegal double move
  logic                             quad_up;    // quadrature direction
  logic                             quad_step;  // quadrature count
  logic                             tick_src;   // timer input event
  logic [7:0]                       pre_lim;    // prescale limit
  logic                             tmr_step;   // timer count
  logic                             tmr_up;     // timer direction
  logic                             step;       // any count
  logic                             up;         // count direction
  logic                             idx_ok;     // phase levels qualify
  logic                             idx_fire;   // index reset
  logic                             err_evt;    // count error event
  logic                             at_max;     // count equals maximum
  logic                             at_zero;    // count equals zero
  logic                             wrap_evt;   // match reset event
  logic [enc_pkg::DATA_W-1:0]       pos_next;   // counted value
  logic [enc_pkg::DATA_W-1:0]       ctrl_wmask; // writable control bits
  logic [enc_pkg::IRQ_W-1:0]        ev_v;       // events to status
  logic [enc_pkg::DATA_W-1:0]       rd_mux;     // read selection
  logic                             wr_ctrl;
  logic                             wr_filt;
  logic                             wr_pos;
  logic                             wr_max;
  logic                             wr_stat;
  logic                             wr_mask;

  // byte-lane merge of a write under a writable-bit mask
  function automatic logic [enc_pkg::DATA_W-1:0] merge(
    input logic [enc_pkg::DATA_W-1:0] old_v,
    input logic [enc_pkg::DATA_W-1:0] new_v,
    input logic [1:0]                 be,
    input logic [enc_pkg::DATA_W-1:0] wmask
  );
    logic [enc_pkg::DATA_W-1:0] m;
    m = {{enc_pkg::BYTE_W{be[1]}}, {enc_pkg::BYTE_W{be[0]}}} & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  // write decode
  assign wr_ctrl = reg_wr && (reg_addr == enc_pkg::ADDR_CTRL);
  assign wr_filt = reg_wr && (reg_addr == enc_pkg::ADDR_FILT);
  assign wr_pos  = reg_wr && (reg_addr == enc_pkg::ADDR_POS);
  assign wr_max  = reg_wr && (reg_addr == enc_pkg::ADDR_MAX);
  assign wr_stat = reg_wr && (reg_addr == enc_pkg::ADDR_STAT);
  assign wr_mask = reg_wr && (reg_addr == enc_pkg::ADDR_MASK);

  // filter clock: divide system clock by a power of two
  assign fdiv_lim = (8'h01 << filt_reg.filter_clock_divide) - 8'h01;
  assign fl_tick  = (fdiv_reg == fdiv_lim);

  always_ff @(posedge ref_clk) begin
    if (rst || fl_tick) begin
      fdiv_reg <= 8'h00;
    end else begin
      fdiv_reg <= fdiv_reg + 8'h01;
    end
  end

  // one synchroniser and filter per pin
  assign pins = {index_input, phase_b_input, phase_a_input};

  genvar gi;
  generate
    for (gi = 0; gi < enc_pkg::NPIN; gi++) begin : g_pin
      enc_input_filter u_flt (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .tick     (fl_tick),
        .pin      (pins[gi]),
        .sync_out (sync_v[gi]),
        .filt_out (filt_v[gi])
      );
    end
  endgenerate

  // filter bypass and phase swap
  assign sel_v  = filt_reg.filter_enable ? filt_v : sync_v;
  assign a_in   = ctrl_reg.phase_swap ? sel_v[1] : sel_v[0];
  assign b_in   = ctrl_reg.phase_swap ? sel_v[0] : sel_v[1];
  assign idx_in = sel_v[2];

  // previous pin levels for edge detection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      a_q   <= 1'h0;
      b_q   <= 1'h0;
      idx_q <= 1'h0;
    end else begin
      a_q   <= a_in;
      b_q   <= b_in;
      idx_q <= idx_in;
    end
  end

  // mode decode; 000, 010 and 011 leave everything idle
  assign is_quad   = ctrl_reg.mode_selector[2];
  assign is_x4     = ctrl_reg.mode_selector[1];
  assign idx_mode  = is_quad && !ctrl_reg.mode_selector[0];
  assign is_timer  = (ctrl_reg.mode_selector == enc_pkg::MODE_TIMER);
  assign wrap_mode = (is_quad && ctrl_reg.mode_selector[0]) || is_timer;
  assign running   = !(ctrl_reg.idle_stop && idle_mode);

  // quadrature step and direction
  assign a_chg     = a_in ^ a_q;
  assign b_chg     = b_in ^ b_q;
  assign both_chg  = a_chg && b_chg;
  assign quad_up   = a_in ^ b_q;
  assign quad_step = is_quad && (is_x4 ? (a_chg ^ b_chg) : (a_chg && !b_chg));

  // timer prescale limit
  always_comb begin
    case (ctrl_reg.timer_prescale)
      enc_pkg::PRE_1:  pre_lim = enc_pkg::LIM_1;
      enc_pkg::PRE_8:  pre_lim = enc_pkg::LIM_8;
      enc_pkg::PRE_64: pre_lim = enc_pkg::LIM_64;
      default:         pre_lim = enc_pkg::LIM_256;
    endcase
  end

  // timer input and direction
  assign tick_src = ctrl_reg.timer_clock_source ? (a_in && !a_q) : 1'h1;
  assign tmr_step = is_timer && tick_src && (pre_reg == pre_lim);
  assign tmr_up   = ctrl_reg.direction_source ? b_in
                                              : ctrl_reg.direction_status;

  // prescaler counts input events, only in timer mode
  always_ff @(posedge ref_clk) begin
    if (rst || !is_timer || (running && tmr_step)) begin
      pre_reg <= 8'h00;
    end else if (running && tick_src) begin
      pre_reg <= pre_reg + 8'h01;
    end
  end

  assign step = running && (quad_step || tmr_step);
  assign up   = is_quad ? quad_up : tmr_up;

  // index qualification by the match value
  always_comb begin
    if (is_x4) begin
      idx_ok = (b_in == filt_reg.index_match_value[1]) &&
               (a_in == filt_reg.index_match_value[0]);
    end else begin
      idx_ok = ((filt_reg.index_match_value[1] ? b_in : a_in) ==
                filt_reg.index_match_value[0]);
    end
  end

  assign idx_fire = running && idx_mode && ctrl_reg.index_reset_enable &&
                    idx_in && !idx_q && idx_ok;
  assign err_evt  = running && idx_mode && both_chg;

  // next count with match reset
  assign at_max   = (pos_reg == max_reg);
  assign at_zero  = (pos_reg == enc_pkg::POS_RST);
  assign wrap_evt = step && wrap_mode && (up ? at_max : at_zero);

  always_comb begin
    if (idx_fire) begin
      pos_next = enc_pkg::POS_RST;
    end else if (up) begin
      pos_next = (wrap_mode && at_max) ? enc_pkg::POS_RST : pos_reg + 16'h0001;
    end else begin
      pos_next = (wrap_mode && at_zero) ? max_reg : pos_reg - 16'h0001;
    end
  end

  // position count; a software write wins over a count
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pos_reg <= enc_pkg::POS_RST;
    end else if (wr_pos) begin
      pos_reg <= merge(pos_reg, reg_wdata, reg_be, enc_pkg::FULL_WMASK);
    end else if (step || idx_fire) begin
      pos_reg <= pos_next;
    end
  end

  // maximum count
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      max_reg <= enc_pkg::MAX_RST;
    end else if (wr_max) begin
      max_reg <= merge(max_reg, reg_wdata, reg_be, enc_pkg::FULL_WMASK);
    end
  end

  // direction is hardware-owned in quadrature modes
  assign ctrl_wmask = is_quad ? (enc_pkg::CTRL_WMASK & ~enc_pkg::CTRL_DIR)
                              : enc_pkg::CTRL_WMASK;

  // control/status: write, then hardware updates; error set beats clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg <= enc_pkg::CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= enc_pkg::enc_ctrl_t'(merge(ctrl_reg, reg_wdata, reg_be, ctrl_wmask));
      end
      ctrl_reg.index_state <= idx_in;
      if (is_quad && step) begin
        ctrl_reg.direction_status <= up;
      end
      if (err_evt) begin
        ctrl_reg.count_error_flag <= 1'h1;
      end
    end
  end

  // filter control
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      filt_reg <= enc_pkg::FILT_RST;
    end else if (wr_filt) begin
      filt_reg <= enc_pkg::enc_filt_t'(merge(filt_reg, reg_wdata, reg_be,
                                             enc_pkg::FILT_WMASK));
    end
  end

  // interrupt events: count error unless disabled, and counter reset
  assign ev_v[enc_pkg::EV_ERR] = err_evt && !filt_reg.count_error_irq_disable;
  assign ev_v[enc_pkg::EV_POS] = idx_fire || wrap_evt;

  // sticky status, write one to clear, new event wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_reg <= '0;
    end else if (wr_stat && reg_be[0]) begin
      stat_reg <= (stat_reg & ~reg_wdata[enc_pkg::IRQ_W-1:0]) | ev_v;
    end else begin
      stat_reg <= stat_reg | ev_v;
    end
  end

  // interrupt mask
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_reg <= '0;
    end else if (wr_mask && reg_be[0]) begin
      mask_reg <= reg_wdata[enc_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(stat_reg & mask_reg);

  // read selection; unmapped words read zero
  always_comb begin
    case (reg_addr)
      enc_pkg::ADDR_CTRL: rd_mux = ctrl_reg;
      enc_pkg::ADDR_FILT: rd_mux = filt_reg;
      enc_pkg::ADDR_POS:  rd_mux = pos_reg;
      enc_pkg::ADDR_MAX:  rd_mux = max_reg;
      enc_pkg::ADDR_STAT: rd_mux = {{(enc_pkg::DATA_W-enc_pkg::IRQ_W){1'h0}}, stat_reg};
      enc_pkg::ADDR_MASK: rd_mux = {{(enc_pkg::DATA_W-enc_pkg::IRQ_W){1'h0}}, mask_reg};
      default:            rd_mux = '0;
    endcase
  end

  // read data stand in the cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rd_mux;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_count_up_at_max;
    step && up && wrap_mode && at_max && !wr_pos;
  endsequence

  sequence s_back_to_zero;
    pos_reg == enc_pkg::POS_RST;
  endsequence

  a_match_wrap: assert property (s_count_up_at_max |=> s_back_to_zero)
    else $error("count did not wrap to zero at maximum");

  a_pos_readback: assert property (reg_rd && reg_addr == enc_pkg::ADDR_POS
    |=> reg_rdata == $past(pos_reg))
    else $error("position read returned wrong value");

  a_pos_word_write: assert property (wr_pos && reg_be == 2'h3
    |=> pos_reg == $past(reg_wdata))
    else $error("position write not taken");

  a_err_sticky: assert property (ctrl_reg.count_error_flag && !(wr_ctrl && reg_be[1])
    |=> ctrl_reg.count_error_flag)
    else $error("count error flag lost");

  a_err_mode: assert property ($rose(ctrl_reg.count_error_flag) && !$past(wr_ctrl)
    |-> $past(idx_mode))
    else $error("count error outside index modes");

  a_dir_follow: assert property (is_quad && step ##1 !wr_ctrl
    |-> ctrl_reg.direction_status == $past(quad_up))
    else $error("direction status wrong");

  a_index_reset: assert property (idx_fire && !wr_pos |=> s_back_to_zero)
    else $error("index pulse did not reset count");

  a_off_hold: assert property (!is_quad && !is_timer && !wr_pos
    |=> pos_reg == $past(pos_reg))
    else $error("count moved while disabled");

  a_count_error_irq_disable_block: assert property (filt_reg.count_error_irq_disable
    && !stat_reg[enc_pkg::EV_ERR] |=> !stat_reg[enc_pkg::EV_ERR])
    else $error("disabled count error raised status");

  a_timer_rate: assert property (is_timer && !ctrl_reg.timer_clock_source && running
    && ctrl_reg.timer_prescale == enc_pkg::PRE_8 && pre_reg == 8'h00 && !wr_ctrl
    |-> !tmr_step ##7 tmr_step)
    else $error("timer prescale 1:8 wrong");

endmodule

`default_nettype wire

//--- tb/enc_model.sv
// encoder partner: a quadrature source that drives phase and index pins.
// assumes the bench pulses up, dn or jump for one cycle at a time.
`default_nettype none

module enc_model (
  // clock
  input  wire logic ref_clk,
  // step commands
  input  wire logic up,
  input  wire logic dn,
  input  wire logic jump,
  input  wire logic idx_req,
  // encoder pins
  output logic      pa,
  output logic      pb,
  output logic      pi
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] ph = 2'h0;  // position in the four-state cycle

  // one quarter cycle per up or dn command; jump moves half a cycle, both phases at once, on purpose
  always_ff @(posedge ref_clk) begin
    if (up) begin
      ph <= ph + 2'h1;
    end else if (dn) begin
      ph <= ph - 2'h1;
    end else if (jump) begin
      ph <= ph + 2'h2;
    end
  end

  // counting up makes phase a lead phase b
  assign pa = ph[1] ^ ph[0];
  assign pb = ph[1];
  assign pi = idx_req;
endmodule

`default_nettype wire

//--- tb/tb.sv
// testbench for the encoder block: register port, counting modes, interrupt.
// assumes the encoder model drives the pins; inputs are unfiltered except in the filtered-pin test.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [2:0]  a;
    logic [15:0] v;
  } enc_row_t;

  logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq;
  logic [2:0]  reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, got;
  logic [1:0]  reg_be = 2'h3;
  logic up = 1'b0, dn = 1'b0, jump = 1'b0, idx = 1'b0, pa, pb, pi;
  int fails = 0, samples_checked = 0;
  enc_row_t rows [7];

  enc_quad_decoder enc_quad_decoder_i (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .phase_a_input(pa), .phase_b_input(pb), .index_input(pi),
    .idle_mode(1'b0), .irq(irq));
  enc_model enc_model_i (.ref_clk(ref_clk), .up(up), .dn(dn), .jump(jump),
    .idx_req(idx), .pa(pa), .pb(pb), .pi(pi));

  // 25 MHz clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // one-cycle write strobe with byte enables
  task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_be    <= be;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // one-cycle read strobe; data stand only in the following cycle
  task automatic rd(input logic [2:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    got = reg_rdata;
  endtask

  // count one comparison and report a miss
  task automatic cmp(input logic ok);
    samples_checked++;
    if (!ok) begin
      fails++;
      $display("Error at %0t: unexpected value %h", $time, got);
    end
  endtask

  task automatic chk(input logic [2:0] a, input logic [15:0] e);
    rd(a);
    cmp(got === e);
  endtask

  // n encoder steps, each held long enough for the synchroniser
  task automatic mv(input int n, input logic u);
    repeat (n) begin
      @(posedge ref_clk);
      up <= u;
      dn <= !u;
      @(posedge ref_clk);
      up <= 1'b0;
      dn <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask

  // index pulse held over several cycles
  task automatic pulse;
    @(posedge ref_clk);
    idx <= 1'b1;
    repeat (6) @(posedge ref_clk);
    idx <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask

  // both phases in one step, an illegal move
  task automatic jmp;
    @(posedge ref_clk);
    jump <= 1'b1;
    @(posedge ref_clk);
    jump <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask

  // summary line, verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    close_out();
  end

  initial begin
    rows = '{'{enc_pkg::ADDR_CTRL, enc_pkg::CTRL_RST}, '{enc_pkg::ADDR_FILT, enc_pkg::FILT_RST},
             '{enc_pkg::ADDR_POS, enc_pkg::POS_RST}, '{enc_pkg::ADDR_MAX, enc_pkg::MAX_RST},
             '{enc_pkg::ADDR_STAT, 16'h0000}, '{enc_pkg::ADDR_MASK, 16'h0000},
             '{3'h6, 16'h0000}};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    wr(3'h6, 16'h5a5a, 2'h3);
    // reset values and the unmapped word
    foreach (rows[i]) chk(rows[i].a, rows[i].v);
    wr(enc_pkg::ADDR_MAX, 16'h1234, 2'h1);
    chk(enc_pkg::ADDR_MAX, 16'hff34);
    // x4 with index reset: up then down; the count is only read by words
    wr(enc_pkg::ADDR_CTRL, 16'h0600, 2'h3);
    mv(5, 1'b1);
    chk(enc_pkg::ADDR_POS, 16'h0005);
    chk(enc_pkg::ADDR_CTRL, 16'h0e00);
    mv(2, 1'b0);
    chk(enc_pkg::ADDR_POS, 16'h0003);
    // index with wrong phase levels, then with matching levels
    wr(enc_pkg::ADDR_CTRL, 16'h0604, 2'h3);
    pulse();
    chk(enc_pkg::ADDR_POS, 16'h0003);
    wr(enc_pkg::ADDR_FILT, 16'h0400, 2'h3);
    pulse();
    chk(enc_pkg::ADDR_POS, 16'h0000);
    chk(enc_pkg::ADDR_STAT, 16'h0002);
    got = {15'h0000, irq};
    cmp(irq === 1'b0);
    // irq follows registers that change on the strobe edge: look just after it
    wr(enc_pkg::ADDR_MASK, 16'h0002, 2'h3);
    #1;
    got = {15'h0000, irq};
    cmp(irq === 1'b1);
    wr(enc_pkg::ADDR_STAT, 16'h0002, 2'h3);
    #1;
    got = {15'h0000, irq};
    cmp(irq === 1'b0);
    // x4 match mode wraps after the maximum
    wr(enc_pkg::ADDR_CTRL, 16'h0700, 2'h3);
    wr(enc_pkg::ADDR_MAX, 16'h0002, 2'h3);
    mv(3, 1'b1);
    chk(enc_pkg::ADDR_POS, 16'h0000);
    // x2 counts only phase a edges
    wr(enc_pkg::ADDR_CTRL, 16'h0500, 2'h3);
    wr(enc_pkg::ADDR_MAX, 16'hffff, 2'h3);
    mv(4, 1'b1);
    chk(enc_pkg::ADDR_POS, 16'h0002);
    // swapped phases count the other way
    wr(enc_pkg::ADDR_CTRL, 16'h0680, 2'h3);
    wr(enc_pkg::ADDR_POS, 16'h0000, 2'h3);
    mv(2, 1'b1);
    chk(enc_pkg::ADDR_POS, 16'hfffe);
    // both phases change together
    wr(enc_pkg::ADDR_STAT, 16'h0003, 2'h3);
    jmp();
    chk(enc_pkg::ADDR_STAT, 16'h0001);
    // timer, prescale 1:8, software direction up: one count every 8 cycles;
    // direction is writable only outside quadrature modes, so leave them first
    wr(enc_pkg::ADDR_POS, 16'h0000, 2'h3);
    wr(enc_pkg::ADDR_CTRL, 16'h0000, 2'h3);
    wr(enc_pkg::ADDR_CTRL, 16'h0908, 2'h3);
    repeat (78) @(posedge ref_clk);
    wr(enc_pkg::ADDR_CTRL, 16'h0000, 2'h3);
    chk(enc_pkg::ADDR_POS, 16'h000a);
    // count error with its interrupt disabled: flag set, status quiet
    wr(enc_pkg::ADDR_FILT, 16'h0100, 2'h3);
    wr(enc_pkg::ADDR_CTRL, 16'h0600, 2'h3);
    wr(enc_pkg::ADDR_STAT, 16'h0003, 2'h3);
    jmp();
    chk(enc_pkg::ADDR_STAT, 16'h0000);
    chk(enc_pkg::ADDR_CTRL, 16'h8600);
    // filtered pins count as well, only later
    wr(enc_pkg::ADDR_FILT, 16'h0080, 2'h3);
    wr(enc_pkg::ADDR_POS, 16'h0000, 2'h3);
    mv(2, 1'b1);
    repeat (4) @(posedge ref_clk);
    chk(enc_pkg::ADDR_POS, 16'h0002);
    // x2 index looks only at the phase chosen by the match value
    wr(enc_pkg::ADDR_CTRL, 16'h0404, 2'h3);
    wr(enc_pkg::ADDR_FILT, 16'h0400, 2'h3);
    pulse();
    chk(enc_pkg::ADDR_POS, 16'h0002);
    wr(enc_pkg::ADDR_FILT, 16'h0200, 2'h3);
    pulse();
    chk(enc_pkg::ADDR_POS, 16'h0000);
    // timer on phase a rises, direction from phase b: low counts down to maximum
    wr(enc_pkg::ADDR_POS, 16'h0000, 2'h3);
    wr(enc_pkg::ADDR_CTRL, 16'h0103, 2'h3);
    mv(4, 1'b1);
    chk(enc_pkg::ADDR_POS, 16'hffff);
    // reset in mid-run brings every register back
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i]) chk(rows[i].a, rows[i].v);
    got = {15'h0000, irq};
    cmp(irq === 1'b0);
    close_out();
  end
endmodule

`default_nettype wire
